// ---- pmx_pad_model.sv ----
// pad model for the routing block: resolves every package pin.
// assumes undriven pads are pulled to the level the bench puts on ext_i.
`timescale 1ns/1ps
module pmx_pad_model
    import pmx_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] pin_out_i,
    input  wire logic [NUM_PINS-1:0] pin_oe_i,
    input  wire logic [NUM_PINS-1:0] ext_i,
    output logic      [NUM_PINS-1:0] pin_in_o
);
    // a released pad shows the pull level, never the last driven value
    assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule

// ---- pmx_pin_route.sv ----
// pin routing multiplexer: places peripheral signals onto port pins.
// assumes peripherals on clock_i; pins asynchronous, synchronised here.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module pmx_pin_route
    import pmx_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic [2:0]          addr_i,
    input  wire logic [7:0]          wr_data_i,
    input  wire logic                wr_stb_i,
    input  wire logic                rd_stb_i,
    output logic      [7:0]          rd_data_o,
    input  wire logic [5:0]          evt_i,
    input  wire logic [3:0]          lut_i,
    input  wire logic [15:0]         ser_out_i,
    input  wire logic [15:0]         ser_oe_i,
    output logic      [15:0]         ser_in_o,
    input  wire logic [3:0]          spi_out_i,
    input  wire logic [3:0]          spi_oe_i,
    output logic      [3:0]          spi_in_o,
    input  wire logic [3:0]          twi_out_i,
    input  wire logic [3:0]          twi_oe_i,
    input  wire logic                twi_dual_i,
    output logic      [3:0]          twi_in_o,
    output logic      [2:0]          timer_a_pins_o,
    output logic      [3:0]          capture_timer_pins_o,
    input  wire logic [NUM_PINS-1:0] pin_in_i,
    output logic      [NUM_PINS-1:0] pin_out_o,
    output logic      [NUM_PINS-1:0] pin_oe_o
);
    pmx_state_t q;
    pmx_state_t n;

    always_comb begin
        int                  idx;
        int                  host;
        int                  cli;
        logic [NUM_PINS-1:0] dv;
        logic [NUM_PINS-1:0] de;
        idx  = 0;
        host = 0;
        cli  = 0;
        dv   = '0;
        de   = '0;
        n    = q;
        // first stage only feeds the second
        n.sync1   = pin_in_i;
        n.sync2   = q.sync1;
        n.rd_data = 8'h00;
        if (wr_stb_i) begin
            case (addr_i)
                OFF_EVT: n.evt_route = wr_data_i & MASK_EVT;
                OFF_LUT: n.lut_route = wr_data_i & MASK_LUT;
                OFF_SER: n.ser_route = wr_data_i & MASK_SER;
                OFF_TWS: n.tws_route = wr_data_i & MASK_TWS;
                OFF_TCA: n.tca_route = wr_data_i & MASK_TCA;
                OFF_TCB: n.tcb_route = wr_data_i & MASK_TCB;
                default: ;
            endcase
        end
        if (rd_stb_i) begin
            case (addr_i)
                OFF_EVT: n.rd_data = q.evt_route;
                OFF_LUT: n.rd_data = q.lut_route;
                OFF_SER: n.rd_data = q.ser_route;
                OFF_TWS: n.rd_data = q.tws_route;
                OFF_TCA: n.rd_data = q.tca_route;
                OFF_TCB: n.rd_data = q.tcb_route;
                default: n.rd_data = 8'h00;
            endcase
        end
        // lowest priority first; later groups overwrite a shared pin
        for (int i = 0; i < 6; i++) begin
            if (!q.evt_route[i]) begin
                idx     = i * PORT_W + EVT_DEF_BIT;
                dv[idx] = evt_i[i];
                de[idx] = 1'b1;
            end else if (EVT_ALT_OK[i]) begin
                idx     = i * PORT_W + EVT_ALT_BIT;
                dv[idx] = evt_i[i];
                de[idx] = 1'b1;
            end
        end
        for (int l = 0; l < 4; l++) begin
            idx     = LUT_PORT[l] + (q.lut_route[l] ? LUT_ALT_BIT : LUT_DEF_BIT);
            dv[idx] = lut_i[l];
            de[idx] = 1'b1;
        end
        n.twi_in = 4'h0;
        host     = -1;
        case (q.tws_route[5:4])
            SEL_DEF: begin
                host = PA;
                cli  = PC;
            end
            SEL_ALT1: begin
                host = PA;
                cli  = PF;
            end
            SEL_ALT2: begin
                host = PC;
                cli  = PF;
            end
            default: ;
        endcase
        if (host >= 0) begin
            for (int k = 0; k < 2; k++) begin
                idx         = host + TWI_BIT + k;
                dv[idx]     = twi_out_i[k];
                de[idx]     = twi_oe_i[k];
                n.twi_in[k] = q.sync2[idx];
                if (twi_dual_i) begin
                    idx             = cli + TWI_BIT + k;
                    dv[idx]         = twi_out_i[2+k];
                    de[idx]         = twi_oe_i[2+k];
                    n.twi_in[2+k]   = q.sync2[idx];
                end
            end
        end
        n.spi_in = 4'h0;
        if (q.tws_route[1:0] == SEL_DEF) begin
            for (int k = 0; k < 4; k++) begin
                idx         = PA + SPI_BIT + k;
                dv[idx]     = spi_out_i[k];
                de[idx]     = spi_oe_i[k];
                n.spi_in[k] = q.sync2[idx];
            end
        end
        n.ser_in = 16'h0000;
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < SER_PINS; k++) begin
                idx = -1;
                if (q.ser_route[2*s+1 -: 2] == SEL_DEF) begin
                    idx = SER_PORT[s] + k;
                end else if (q.ser_route[2*s+1 -: 2] == SEL_ALT1
                             && k < SER_ALT_CNT[s]) begin
                    idx = SER_PORT[s] + SER_ALT_BIT[s] + k;
                end
                // reserved and disconnect codes leave the port off all pins
                if (idx >= 0) begin
                    dv[idx]                = ser_out_i[s*SER_PINS+k];
                    de[idx]                = ser_oe_i[s*SER_PINS+k];
                    n.ser_in[s*SER_PINS+k] = q.sync2[idx];
                end
            end
        end
        n.pin_out = dv;
        n.pin_oe  = de;
        if (rst_i) begin
            n = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        q <= n;
    end

    assign rd_data_o            = q.rd_data;
    assign ser_in_o             = q.ser_in;
    assign spi_in_o             = q.spi_in;
    assign twi_in_o             = q.twi_in;
    assign timer_a_pins_o       = q.tca_route[2:0];
    assign capture_timer_pins_o = q.tcb_route[3:0];
    assign pin_out_o            = q.pin_out;
    assign pin_oe_o             = q.pin_oe;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    sequence s_write_evt;
        wr_stb_i && addr_i == OFF_EVT;
    endsequence
    sequence s_read_evt;
        rd_stb_i && addr_i == OFF_EVT;
    endsequence

    a_write_mask_read: assert property (
        s_write_evt ##1 s_read_evt |=> rd_data_o == ($past(wr_data_i, 2) & MASK_EVT))
        else $error("event route readback does not match masked write");
    a_reserved_bits_zero: assert property (
        rd_stb_i && addr_i == OFF_TWS |=> rd_data_o[7:6] == 2'h0 && rd_data_o[3:2] == 2'h0)
        else $error("reserved route bits read nonzero");
    a_reset_clears_routes: assert property (disable iff (1'b0)
        rst_i |=> q.evt_route == RESET_ROUTE && q.ser_route == RESET_ROUTE
                  && q.tws_route == RESET_ROUTE && !pin_oe_o[0])
        else $error("route registers not cleared by reset");
    a_evt_d_position: assert property (
        q.evt_route[3] |=> pin_oe_o[PD+7] && pin_out_o[PD+7] == $past(evt_i[3])
                           && !pin_oe_o[PD+2])
        else $error("event output d not on alternative pin");
    a_evt_e_reserved: assert property (
        q.evt_route[4] |=> !pin_oe_o[PE+2])
        else $error("reserved event e setting still drives a pin");
    a_logic_table_1_sel_alt_pin: assert property (
        q.lut_route[1] && q.ser_route[3:2] != SEL_ALT1
        |=> pin_oe_o[PC+6] && pin_out_o[PC+6] == $past(lut_i[1]))
        else $error("logic table 1 not on alternative pin");
    a_ser0_alt_drive: assert property (
        q.ser_route[1:0] == SEL_ALT1
        |=> pin_out_o[PA+4] == $past(ser_out_i[0]) && pin_oe_o[PA+4] == $past(ser_oe_i[0]))
        else $error("serial port 0 not on alternative pins");
    a_ser3_disconnect: assert property (
        q.ser_route[7:6] == 2'h3 [*2] |-> ser_in_o[15:12] == 4'h0)
        else $error("disconnected serial port 3 still sees a pin");
    a_twi_alt2_host: assert property (
        q.tws_route[5:4] == SEL_ALT2 && q.ser_route[3:2] != SEL_DEF
        |=> pin_oe_o[PC+2] == $past(twi_oe_i[0]) && pin_out_o[PC+2] == $past(twi_out_i[0])
            && pin_oe_o[PC+3] == $past(twi_oe_i[1]) && pin_out_o[PC+3] == $past(twi_out_i[1]))
        else $error("two-wire host not moved to port c");
    a_spi_default_pins: assert property (
        q.tws_route[1:0] == SEL_DEF && q.ser_route[1:0] != SEL_ALT1
        |=> pin_out_o[PA+7:PA+4] == $past(spi_out_i) && pin_oe_o[PA+7:PA+4] == $past(spi_oe_i))
        else $error("spi port not on default pins");
endmodule

// ---- pmx_pkg.sv ----
// constants, register map and state type of the pin routing multiplexer.
// assumes one 200 MHz clock and a plain register port with 3-bit byte offsets.
// How it works
// - software moves each peripheral between default pins, alternative pins or none.
// - event output f sits on pf2 when its bit is 0; 1 drives nothing.
// - event output e sits on pe2 when its bit is 0; 1 drives nothing.
// - event output d uses pd2 when its bit is 0, pd7 when 1.
// - event output c uses pc2 when its bit is 0, pc7 when 1.
// - event output b sits on pb2 when its bit is 0; 1 drives nothing.
// - event output a uses pa2 when its bit is 0, pa7 when 1.
// - logic table 3 output uses pf3 when 0, pf6 when 1.
// - logic table 2 output uses pd3 when 0, pd6 when 1.
// - logic table 1 output uses pc3 when 0, pc6 when 1.
// - logic table 0 output uses pa3 when 0, pa6 when 1.
// - serial port 3 on pb3..0, or pb5..4, 3 disconnects, 2 reserved.
// - serial port 2 on pf3..0, or pf6..4, 3 disconnects, 2 reserved.
// - serial port 1 on pc3..0, or pc7..4, 3 disconnects, 2 reserved.
// - serial port 0 on pa3..0, or pa7..4, 3 disconnects, 2 reserved.
// - two-wire on pa3..2/pc3..2 client, pa/pf, or pc/pf; 3 reserved.
// - spi port field 0 places the spi port on pa7..4.
package pmx_pkg;
    localparam int NUM_PINS = 48;
    localparam int PORT_W   = 8;
    // pin index = port base + bit
    localparam int PA = 0;
    localparam int PB = 8;
    localparam int PC = 16;
    localparam int PD = 24;
    localparam int PE = 32;
    localparam int PF = 40;
    // register offsets
    localparam logic [2:0] OFF_EVT = 3'h0;
    localparam logic [2:0] OFF_LUT = 3'h1;
    localparam logic [2:0] OFF_SER = 3'h2;
    localparam logic [2:0] OFF_TWS = 3'h3;
    localparam logic [2:0] OFF_TCA = 3'h4;
    localparam logic [2:0] OFF_TCB = 3'h5;
    // writable bits of each register
    localparam logic [7:0] MASK_EVT = 8'h3f;
    localparam logic [7:0] MASK_LUT = 8'h0f;
    localparam logic [7:0] MASK_SER = 8'hff;
    localparam logic [7:0] MASK_TWS = 8'h33;
    localparam logic [7:0] MASK_TCA = 8'h07;
    localparam logic [7:0] MASK_TCB = 8'h0f;
    localparam logic [7:0] RESET_ROUTE = 8'h00;
    // event outputs: default bit 2, alternative bit 7 of the own port
    localparam int EVT_DEF_BIT = 2;
    localparam int EVT_ALT_BIT = 7;
    localparam logic [5:0] EVT_ALT_OK = 6'h0d;
    // logic table outputs: bit 3 default, bit 6 alternative
    localparam int LUT_DEF_BIT = 3;
    localparam int LUT_ALT_BIT = 6;
    localparam int LUT_PORT[4] = '{PA, PC, PD, PF};
    // serial ports: default four pins at bit 0, alternative group
    localparam logic [1:0] SEL_DEF  = 2'h0;
    localparam logic [1:0] SEL_ALT1 = 2'h1;
    localparam logic [1:0] SEL_ALT2 = 2'h2;
    localparam int SER_PORT[4]    = '{PA, PC, PF, PB};
    localparam int SER_ALT_BIT[4] = '{4, 4, 4, 4};
    localparam int SER_ALT_CNT[4] = '{4, 4, 3, 2};
    localparam int SER_PINS       = 4;
    // two-wire: sda at bit 2, scl at bit 3
    localparam int TWI_BIT = 2;
    localparam int SPI_BIT = 4;

    typedef struct packed {
        logic [7:0]          evt_route;
        logic [7:0]          lut_route;
        logic [7:0]          ser_route;
        logic [7:0]          tws_route;
        logic [7:0]          tca_route;
        logic [7:0]          tcb_route;
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic [NUM_PINS-1:0] pin_out;
        logic [NUM_PINS-1:0] pin_oe;
        logic [15:0]         ser_in;
        logic [3:0]          spi_in;
        logic [3:0]          twi_in;
        logic [7:0]          rd_data;
    } pmx_state_t;
endpackage

// ---- test_pmx_pin_route.sv ----
// bench for the pin routing block: register port and pin placement.
// assumes a 200 MHz clock and the pad model standing for the pins.
`timescale 1ns/1ps
module test_pmx_pin_route
    import pmx_pkg::*;
;
    logic                clock_i, rst_i, wr_stb, rd_stb, twi_dual;
    logic [2:0]          addr, tma;
    logic [3:0]          tcb;
    logic [7:0]          wr_data, rd_data;
    logic [5:0]          evt;
    logic [3:0]          lut, spi_out, spi_oe, spi_in, twi_out, twi_oe, twi_in;
    logic [15:0]         ser_out, ser_oe, ser_in;
    logic [NUM_PINS-1:0] ext, pin_in, pin_out, pin_oe;
    logic [7:0]          msk[6] = '{8'h3f, 8'h0f, 8'hff, 8'h33, 8'h07, 8'h0f};
    logic [7:0]          tw[4]  = '{8'h03, 8'h13, 8'h23, 8'h33};
    logic [2:0]          tm[4]  = '{3'h3, 3'h5, 3'h6, 3'h0};
    int                  lp[4]  = '{0, 16, 24, 40};
    int                  sp[4]  = '{0, 16, 40, 8};
    int                  n_mismatch = 0, total_checks = 0, cycles = 0, i;

    pmx_pin_route dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wr_data),
        .wr_stb_i(wr_stb), .rd_stb_i(rd_stb), .rd_data_o(rd_data), .evt_i(evt), .lut_i(lut),
        .ser_out_i(ser_out), .ser_oe_i(ser_oe), .ser_in_o(ser_in), .spi_out_i(spi_out),
        .spi_oe_i(spi_oe), .spi_in_o(spi_in), .twi_out_i(twi_out), .twi_oe_i(twi_oe),
        .twi_dual_i(twi_dual), .twi_in_o(twi_in), .timer_a_pins_o(tma),
        .capture_timer_pins_o(tcb), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
    pmx_pad_model pads (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_i(ext),
        .pin_in_o(pin_in));

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the whole run needs about 130 cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_pin(input int idx, input logic [1:0] exp);
        cmp($sformatf("pin %0d oe,out", idx), {14'h0, exp}, {14'h0, pin_oe[idx], pin_out[idx]});
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clock_i);
        wr_stb  <= 1'b0;
    endtask
    // read data stand only in the cycle after the read edge
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock_i);
        rd_stb <= 1'b0;
        #1 cmp($sformatf("reg %0d", a), {8'h0, exp}, {8'h0, rd_data});
    endtask
    // pins follow after one edge, pin inputs after four
    task automatic settle();
        repeat (4) @(posedge clock_i);
        #1;
    endtask

    initial begin
        {rst_i, wr_stb, rd_stb, twi_dual, addr, wr_data} = '0;
        {evt, lut, spi_out, spi_oe, twi_out, twi_oe, ser_out, ser_oe} = '0;
        rst_i = 1'b1;
        ext   = '1;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        for (i = 0; i < 8; i++) rd(i[2:0], 8'h00);
        for (i = 0; i < 6; i++) begin
            wr(i[2:0], 8'hff);
            rd(i[2:0], msk[i]);
        end
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        cmp("timer a pins", 16'h0007, {13'h0, tma});
        cmp("capture timer pins", 16'h000f, {12'h0, tcb});
        $display("test registers done");
        @(posedge clock_i);
        evt <= 6'h3f;
        lut <= 4'hf;
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        settle();
        for (i = 0; i < 6; i++) cmp_pin(i * 8 + 2, 2'b11);
        for (i = 0; i < 4; i++) cmp_pin(lp[i] + 3, 2'b11);
        wr(3'h0, 8'h3f);
        wr(3'h1, 8'h0f);
        settle();
        for (i = 0; i < 6; i++) begin
            cmp_pin(i * 8 + 2, 2'b00);
            cmp_pin(i * 8 + 7, (i == 0 || i == 2 || i == 3) ? 2'b11 : 2'b00);
        end
        for (i = 0; i < 4; i++) begin
            cmp_pin(lp[i] + 6, 2'b11);
            cmp_pin(lp[i] + 3, 2'b00);
        end
        $display("test event and table outputs done");
        @(posedge clock_i);
        ser_out <= '1;
        ser_oe  <= '1;
        wr(3'h2, 8'h00);
        settle();
        for (i = 0; i < 4; i++) cmp_pin(sp[i], 2'b11);
        cmp("serial in", 16'hffff, ser_in);
        wr(3'h2, 8'h55);
        settle();
        for (i = 0; i < 4; i++) begin
            cmp_pin(sp[i] + 4, 2'b11);
            cmp_pin(sp[i], 2'b00);
        end
        cmp("serial in", 16'h37ff, ser_in);
        wr(3'h2, 8'hff);
        settle();
        for (i = 0; i < 4; i++) cmp_pin(sp[i] + 4, 2'b00);
        cmp("serial in", 16'h0000, ser_in);
        wr(3'h2, 8'haa);
        settle();
        for (i = 0; i < 4; i++) cmp_pin(sp[i], 2'b00);
        $display("test serial ports done");
        @(posedge clock_i);
        spi_out <= '1;
        spi_oe  <= '1;
        wr(3'h3, 8'h00);
        settle();
        cmp_pin(4, 2'b11);
        cmp("spi in", 16'h000f, {12'h0, spi_in});
        @(posedge clock_i);
        twi_dual <= 1'b1;
        twi_out  <= '1;
        twi_oe   <= '1;
        for (i = 0; i < 4; i++) begin
            wr(3'h3, tw[i]);
            settle();
            cmp_pin(2, {2{tm[i][0]}});
            cmp_pin(18, {2{tm[i][1]}});
            cmp_pin(42, {2{tm[i][2]}});
        end
        cmp_pin(4, 2'b00);
        $display("test two-wire and spi done");
        @(posedge clock_i);
        rst_i <= 1'b1;
        @(posedge clock_i);
        rst_i <= 1'b0;
        rd(3'h3, 8'h00);
        $display("test second reset done");
        end_sim();
    end
endmodule
